/* File: verilog/ppea_host.sv */
// Host controller that reads, page-writes and protects a parallel nonvolatile memory
//
// Behaviour
// - Write starts with strobe low, outputs off
// - Next page byte within 150 us
// - Page bits fixed across one load; not checked, each byte is loaded at the address it is given
// - Three-byte sequence enables protection
// - Protected writes need sequence prefix
// - Sequences follow page-load timing
// - High voltage pin selects identification area
`timescale 1ns/100ps
`default_nettype none
module ppea_host
    import ppea_pkg::*;
#(
    parameter logic [ADDR_W-1:0] CMD_A0    = 17'h00001,  // Arbitrary default
    parameter logic [ADDR_W-1:0] CMD_A1    = 17'h00002,  // Arbitrary default
    parameter logic [ADDR_W-1:0] CMD_A2    = 17'h00003,  // Arbitrary default
    parameter logic [DATA_W-1:0] CMD_D0    = 8'h11,      // Arbitrary default
    parameter logic [DATA_W-1:0] CMD_D1    = 8'h22,      // Arbitrary default
    parameter logic [DATA_W-1:0] CMD_LOCK  = 8'h33,      // Enable third byte
    parameter logic [DATA_W-1:0] CMD_UNLK  = 8'h44,      // Disable third byte
    parameter int                WC_CYC    = CYC_WC,     // Poll time limit
    parameter int                PWR_CYC   = CYC_PWRUP,  // Power-up wait
    parameter int                GAP_CYC   = CYC_BLC     // Byte load window
)
(
    input  wire logic              core_clk_in,      // Core clock, 100 MHz
    input  wire logic              rst_b_in,         // Synchronous reset, low
    input  wire logic              req_valid_in,     // Request offered
    output logic                   req_ready_out,    // Request taken
    input  wire logic [1:0]        req_op_in,        // Operation code
    input  wire logic [ADDR_W-1:0] req_addr_in,      // Target address
    input  wire logic [DATA_W-1:0] req_data_in,      // Write data
    input  wire logic              req_last_in,      // Last byte of page
    input  wire logic              req_id_in,        // Use identification area
    input  wire logic              lock_on_in,       // Prefix writes with sequence
    output logic                   rsp_valid_out,    // Answer pulse
    output logic [DATA_W-1:0]      rsp_data_out,     // Read data
    output logic                   rsp_timeout_out,  // Poll gave up
    output logic                   busy_out,         // Controller busy
    output logic [ADDR_W-1:0]      address_bus_out,  // address_bus
    output logic                   chip_sel_b_out,   // Chip select, low
    output logic                   out_en_b_out,     // Output enable, low
    output logic                   wr_strobe_b_out,  // Write strobe, low
    output logic [DATA_W-1:0]      data_bus_out,     // data_bus drive value
    output logic                   data_bus_oe_out,  // data_bus drive enable
    input  wire logic [DATA_W-1:0] data_bus_in,      // data_bus pin level
    output logic                   id_area_hv_out    // id_area_hv_pin request
);
    // Controller states
    typedef enum logic [6:0]
    {
        HS_PWR  = 7'h01,
        HS_IDLE = 7'h02,
        HS_CMD  = 7'h04,
        HS_LOAD = 7'h08,
        HS_GAP  = 7'h10,
        HS_POLL = 7'h20,
        HS_RD   = 7'h40
    } ppea_st_type;

    typedef struct packed
    {
        ppea_st_type        st;       // Controller state
        logic [CNT_W-1:0]   cnt;      // Long timer
        logic [1:0]         step;     // Command byte index
        logic [1:0]         op;       // Current operation
        logic               go;       // Start strobe
        logic               wr;       // Strobe kind
        logic [ADDR_W-1:0]  addr;     // Strobe address
        logic [DATA_W-1:0]  dat;      // Strobe data
        logic [ADDR_W-1:0]  last_a;   // Last written address
        logic [DATA_W-1:0]  last_d;   // Last written data
        logic               lastb;    // Page ends after this byte
        logic               hv;       // Identification area select
        logic               rsp;      // Answer pulse
        logic [DATA_W-1:0]  rdat;     // Answer data
        logic               tmo;      // Poll timed out
    } ppea_host_type;

    ppea_host_type h_q;               // Registered state
    ppea_host_type h_d;               // Next state

    logic [DATA_W-1:0] sync1_q;       // First sync stage
    logic [DATA_W-1:0] sync2_q;       // Second sync stage
    logic              sdone;         // Strobe cycle done
    logic [DATA_W-1:0] srdat;         // Strobe read data

    // Returns the command address for a sequence step
    function automatic logic [ADDR_W-1:0] cmd_addr(input logic [1:0] s);
        cmd_addr = (s == 2'h0) ? CMD_A0 : (s == 2'h1) ? CMD_A1 : CMD_A2;
    endfunction

    // Returns the command byte; third differs for enable and disable
    function automatic logic [DATA_W-1:0] cmd_data(input logic [1:0] s, input logic [1:0] op);
        cmd_data = (s == 2'h0) ? CMD_D0 : (s == 2'h1) ? CMD_D1 :
                   ((op == OP_UNLOCK) ? CMD_UNLK : CMD_LOCK);
    endfunction

    // Two-stage sync of the asynchronous data pins
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end
        else
        begin
            sync1_q <= data_bus_in;
            sync2_q <= sync1_q;
        end
    end

    // Pin timing engine
    ppea_strobe u_strobe
    (
        .core_clk_in     (core_clk_in),
        .rst_b_in        (rst_b_in),
        .go_in           (h_q.go),
        .wr_in           (h_q.wr),
        .addr_in         (h_q.addr),
        .wdata_in        (h_q.dat),
        .pin_data_in     (sync2_q),
        .done_out        (sdone),
        .rdata_out       (srdat),
        .address_bus_out (address_bus_out),
        .chip_sel_b_out  (chip_sel_b_out),
        .out_en_b_out    (out_en_b_out),
        .wr_strobe_b_out (wr_strobe_b_out),
        .data_bus_out    (data_bus_out),
        .data_bus_oe_out (data_bus_oe_out)
    );

    // Next-state logic of the controller
    always_comb
    begin
        h_d     = h_q;
        h_d.go  = 1'b0;
        h_d.rsp = 1'b0;
        h_d.tmo = 1'b0;
        unique case (h_q.st)
            HS_PWR:
            begin
                if (h_q.cnt == CNT_W'(PWR_CYC))
                begin
                    h_d.st  = HS_IDLE;
                end
                else
                begin
                    h_d.cnt = h_q.cnt + 1'b1;
                end
            end
            HS_IDLE, HS_GAP:
            begin
                // close the page before the load window expires
                if (h_q.st == HS_GAP && h_q.cnt == CNT_W'(GAP_CYC - 40))
                begin
                    h_d.st  = HS_POLL;
                    h_d.cnt = '0;
                end
                else if (req_valid_in)
                begin
                    h_d.op  = req_op_in;
                    h_d.hv  = req_id_in;
                    h_d.cnt = '0;
                    h_d.go  = 1'b1;
                    h_d.lastb = req_last_in;
                    // prefix a write only at the start of a page
                    if (req_op_in == OP_LOCK || req_op_in == OP_UNLOCK ||
                        (req_op_in == OP_WRITE && lock_on_in && h_q.st == HS_IDLE))
                    begin
                        h_d.st   = HS_CMD;
                        h_d.step = 2'h0;
                        h_d.wr   = 1'b1;
                        h_d.addr = cmd_addr(2'h0);
                        h_d.dat  = cmd_data(2'h0, req_op_in);
                        h_d.last_a = req_addr_in;
                        h_d.last_d = req_data_in;
                    end
                    else if (req_op_in == OP_WRITE)
                    begin
                        // any byte of the page, any order
                        h_d.st   = HS_LOAD;
                        h_d.wr   = 1'b1;
                        h_d.addr = req_addr_in;
                        h_d.dat  = req_data_in;
                        h_d.last_a = req_addr_in;
                        h_d.last_d = req_data_in;
                    end
                    else
                    begin
                        h_d.st   = HS_RD;
                        h_d.wr   = 1'b0;
                        h_d.addr = req_addr_in;
                    end
                end
                else if (h_q.st == HS_GAP)
                begin
                    h_d.cnt = h_q.cnt + 1'b1;
                end
            end
            HS_CMD:
            begin
                if (sdone)
                begin
                    h_d.go = 1'b1;
                    if (h_q.step == 2'h2)
                    begin
                        // third byte sent: a write loads its own byte, a lock or unlock waits out programming
                        if (h_q.op == OP_WRITE)
                        begin
                            h_d.st   = HS_LOAD;
                            h_d.addr = h_q.last_a;
                            h_d.dat  = h_q.last_d;
                        end
                        else
                        begin
                            h_d.go  = 1'b0;
                            h_d.st  = HS_POLL;
                            h_d.cnt = '0;
                        end
                    end
                    else
                    begin
                        h_d.step = h_q.step + 2'h1;
                        h_d.addr = cmd_addr(h_q.step + 2'h1);
                        h_d.dat  = cmd_data(h_q.step + 2'h1, h_q.op);
                    end
                end
            end
            HS_LOAD:
            begin
                if (sdone)
                begin
                    h_d.rsp = 1'b1;
                    h_d.cnt = '0;
                    // final byte hands over to programming
                    h_d.st  = h_q.lastb ? HS_POLL : HS_GAP;
                end
            end
            HS_POLL:
            begin
                // bit 7 equal to the written data again means programming ended
                if (sdone && h_q.cnt != '0 && srdat[POLL_BIT] == h_q.last_d[POLL_BIT])
                begin
                    h_d.st = HS_IDLE;
                    h_d.rsp = (h_q.op != OP_WRITE);
                end
                // give up past the longest programming period
                else if (h_q.cnt >= CNT_W'(WC_CYC) && !chip_sel_b_out == 1'b0 && !h_q.go)
                begin
                    h_d.st  = HS_IDLE;
                    h_d.tmo = 1'b1;
                    h_d.rsp = (h_q.op != OP_WRITE);
                end
                else
                begin
                    h_d.cnt = h_q.cnt + 1'b1;
                    // reads of the last address act as polls
                    if (!h_q.go && chip_sel_b_out && (sdone || h_q.cnt == '0))
                    begin
                        h_d.go   = 1'b1;
                        h_d.wr   = 1'b0;
                        h_d.addr = h_q.last_a;
                    end
                end
            end
            HS_RD:
            begin
                if (sdone)
                begin
                    h_d.st   = HS_IDLE;
                    h_d.rsp  = 1'b1;
                    h_d.rdat = srdat;
                end
            end
            default:
            begin
                h_d.st = HS_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            h_q <= '{st: HS_PWR, default: '0};
        end
        else
        begin
            h_q <= h_d;
        end
    end

    // Handshake and answer outputs
    assign req_ready_out   = (h_q.st == HS_IDLE || (h_q.st == HS_GAP && h_q.cnt != CNT_W'(GAP_CYC - 40)))
                             && !h_q.go;
    assign busy_out        = (h_q.st != HS_IDLE);
    assign rsp_valid_out   = h_q.rsp;
    assign rsp_data_out    = h_q.rdat;
    assign rsp_timeout_out = h_q.tmo;
    assign id_area_hv_out  = h_q.hv && (h_q.st != HS_IDLE);
endmodule
`default_nettype wire

/* File: verilog/ppea_pkg.sv */
// Package of constants for the paged parallel memory access controller
`default_nettype none
package ppea_pkg;
    // Bus geometry
    localparam int ADDR_W            = 17;           // Width of address_bus
    localparam int DATA_W            = 8;            // Width of data_bus
    localparam int PAGE_LO           = 7;            // Lowest bit of page_select_bits
    localparam int PAGE_BYTES        = 128;          // Bytes in one page
    // Clock rate
    localparam int CLK_MHZ           = 100;          // Core clock in MHz
    // Timing figures in their own units
    localparam int T_PULSE_NS        = 100;          // Least strobe low width
    localparam int T_HIGH_NS         = 50;           // Least strobe high width
    localparam int T_DS_NS           = 50;           // Data setup before strobe rise
    localparam int T_ACC_NS          = 250;          // Slowest read access
    localparam int T_DF_NS           = 55;           // Longest output float time
    localparam int T_WC_MS           = 10;           // programming_period, longest
    localparam int T_BLC_US          = 150;          // byte_load_window, longest
    localparam int T_PWRUP_MS        = 5;            // Power-on write block
    // Cycle counts, least times rounded up
    localparam int CYC_PULSE         = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_HIGH          = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_ACC           = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_DF            = (T_DF_NS * CLK_MHZ + 999) / 1000;
    // Byte gap kept under the load window, rounded down
    localparam int CYC_BLC           = T_BLC_US * CLK_MHZ;
    localparam int CYC_WC            = T_WC_MS * 1000 * CLK_MHZ;
    localparam int CYC_PWRUP         = T_PWRUP_MS * 1000 * CLK_MHZ;
    localparam int CNT_W             = 24;           // Width of the long counter
    // Bit positions of the poll indications
    localparam int POLL_BIT          = 7;            // completion_poll_bit
    localparam int TOGGLE_BIT        = 6;            // busy_toggle_bit
    // Operation codes of the user port
    localparam logic [1:0] OP_READ   = 2'h0;         // Single array read
    localparam logic [1:0] OP_WRITE  = 2'h1;         // One byte into the page
    localparam logic [1:0] OP_LOCK   = 2'h2;         // Enable software_write_lock
    localparam logic [1:0] OP_UNLOCK = 2'h3;         // Disable software_write_lock
endpackage
`default_nettype wire

/* File: verilog/ppea_strobe.sv */
// One strobe cycle on the memory pins: read or write with timed phases
`timescale 1ns/100ps
`default_nettype none
module ppea_strobe
    import ppea_pkg::*;
(
    input  wire logic              core_clk_in,    // Core clock
    input  wire logic              rst_b_in,       // Synchronous reset, low
    input  wire logic              go_in,          // Start a strobe cycle
    input  wire logic              wr_in,          // High for a write
    input  wire logic [ADDR_W-1:0] addr_in,        // Address to present
    input  wire logic [DATA_W-1:0] wdata_in,       // Data for a write
    input  wire logic [DATA_W-1:0] pin_data_in,    // Synchronised data_bus
    output logic                   done_out,       // Cycle complete pulse
    output logic [DATA_W-1:0]      rdata_out,      // Byte sampled by a read
    output logic [ADDR_W-1:0]      address_bus_out,// address_bus
    output logic                   chip_sel_b_out, // Chip select, low active
    output logic                   out_en_b_out,   // Output enable, low active
    output logic                   wr_strobe_b_out,// Write strobe, low active
    output logic [DATA_W-1:0]      data_bus_out,   // data_bus drive value
    output logic                   data_bus_oe_out // data_bus drive enable
);
    // Phases of one cycle
    typedef enum logic [3:0]
    {
        PS_IDLE  = 4'h1,
        PS_LOW   = 4'h2,
        PS_HIGH  = 4'h4,
        PS_FLOAT = 4'h8
    } ppea_ph_type;

    typedef struct packed
    {
        ppea_ph_type        ph;      // Current phase
        logic [7:0]         cnt;     // Phase timer
        logic               wr;      // Cycle is a write
        logic [ADDR_W-1:0]  addr;    // Held address
        logic [DATA_W-1:0]  wdat;    // Held write data
        logic [DATA_W-1:0]  rdat;    // Sampled read data
        logic               done;    // Completion pulse
    } ppea_strb_type;

    ppea_strb_type s_q;              // Registered state
    ppea_strb_type s_d;              // Next state

    // Longest input sync delay plus access time before sampling
    localparam logic [7:0] RD_CYC  = 8'(CYC_ACC + 3);
    localparam logic [7:0] WR_CYC  = 8'(CYC_PULSE);
    localparam logic [7:0] HI_CYC  = 8'(CYC_HIGH);
    localparam logic [7:0] DF_CYC  = 8'(CYC_DF);

    // Phase sequencing
    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        unique case (s_q.ph)
            PS_IDLE:
            begin
                if (go_in)
                begin
                    s_d.ph   = PS_LOW;
                    s_d.wr   = wr_in;
                    s_d.addr = addr_in;
                    s_d.wdat = wdata_in;
                    s_d.cnt  = wr_in ? WR_CYC : RD_CYC;
                end
            end
            PS_LOW:
            begin
                // Strobe width well above the noise filter
                if (s_q.cnt == 8'h00)
                begin
                    if (!s_q.wr)
                    begin
                        s_d.rdat = pin_data_in;
                    end
                    s_d.ph  = s_q.wr ? PS_HIGH : PS_FLOAT;
                    s_d.cnt = s_q.wr ? HI_CYC : DF_CYC;
                end
                else
                begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            PS_HIGH, PS_FLOAT:
            begin
                // Strobe high time, or wait for the device to float
                if (s_q.cnt == 8'h00)
                begin
                    s_d.ph   = PS_IDLE;
                    s_d.done = 1'b1;
                end
                else
                begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            s_q <= '{ph: PS_IDLE, default: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Pin drive, decoded from the registered phase and held values
    // write strobe pulse
    assign chip_sel_b_out  = !(s_q.ph == PS_LOW);
    assign wr_strobe_b_out = !(s_q.ph == PS_LOW && s_q.wr);
    assign out_en_b_out    = !(s_q.ph == PS_LOW && !s_q.wr);
    assign data_bus_oe_out = s_q.wr && (s_q.ph == PS_LOW || s_q.ph == PS_HIGH);
    assign data_bus_out    = s_q.wdat;
    assign address_bus_out = s_q.addr;
    assign rdata_out       = s_q.rdat;
    assign done_out        = s_q.done;
endmodule
`default_nettype wire

/* File: bench/ppea_chk.sv */
// Checker of write strobe timing and request handshake
`timescale 1ns/100ps
`default_nettype none
module ppea_chk
    import ppea_pkg::*;
(
    input wire logic              core_clk_in, rst_b_in, req_valid_in, req_ready_out,
    input wire logic              rsp_valid_out, busy_out, chip_sel_b_out, out_en_b_out,
    input wire logic              wr_strobe_b_out, data_bus_oe_out,
    input wire logic [ADDR_W-1:0] address_bus_out,
    input wire logic [DATA_W-1:0] data_bus_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    // A glitch-length strobe would be dropped by the memory's noise filter
    sequence s_low_run; !wr_strobe_b_out [*8]; endsequence
    sequence s_high_run; wr_strobe_b_out [*5]; endsequence
    a_low_width: assert property ($fell(wr_strobe_b_out) |=> s_low_run) else $error("strobe low short");
    a_high_width: assert property ($rose(wr_strobe_b_out) |-> s_high_run) else $error("strobe high short");
    a_write_oe_off: assert property (!wr_strobe_b_out |-> out_en_b_out) else $error("strobe, outputs on");
    a_write_sel: assert property (!wr_strobe_b_out |-> !chip_sel_b_out) else $error("strobe unselected");
    a_no_fight: assert property (data_bus_oe_out |-> out_en_b_out) else $error("data bus fight");
    a_latch_stable: assert property (!wr_strobe_b_out && !$past(wr_strobe_b_out) |->
        $stable(address_bus_out) && $stable(data_bus_out)) else $error("bus moved under strobe");
    a_rsp_single: assert property (rsp_valid_out |=> !rsp_valid_out) else $error("answer too long");
    a_take_busy: assert property (req_valid_in && req_ready_out |=> busy_out) else $error("idle after take");
endmodule
bind ppea_host ppea_chk ppea_chk_i (.core_clk_in, .rst_b_in, .req_valid_in, .req_ready_out, .rsp_valid_out,
    .busy_out, .chip_sel_b_out, .out_en_b_out, .wr_strobe_b_out, .data_bus_oe_out, .address_bus_out, .data_bus_out);
`default_nettype wire

/* File: bench/ppea_dev_model.sv */
// Behavioural paged memory device seen at its parallel pins
`timescale 1ns/100ps
`default_nettype none
module ppea_dev_model #(parameter int WC = 100, GAP = 200, PWR = 15, ACC = 20)
(
    input  wire logic        clk_in, pwr_ok_in, cs_b_in, oe_b_in, we_b_in, hv_in,
    input  wire logic [16:0] addr_in,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  q_out
);
    // Command bytes as {area, address, data}, matching the controller defaults
    localparam logic [25:0] E0 = 26'h0000111, E1 = 26'h0000222, EL = 26'h0000333, EU = 26'h0000344;
    logic [7:0]  mem [262144];  // Main array plus identification area
    logic [25:0] pq [$];        // Page latch entries
    logic [17:0] la;
    logic [7:0]  ld, lq;
    logic        w, r, wp = 0, rp = 0, tog = 0, lock = 0, lk_n = 0, en, dis;
    int          pw = 0, gap = 0, wc = 0, rc = 0;
    initial foreach (mem[i]) mem[i] = 8'h00;
    initial q_out = 8'h00;
    always @(posedge clk_in)
    begin
        w = !cs_b_in && !we_b_in && oe_b_in;
        r = !cs_b_in && !oe_b_in && we_b_in;
        pw = !pwr_ok_in ? PWR : (pw > 0 ? pw - 1 : 0);
        // address on the later fall, data held to the first rise
        if (w && !wp) la = {hv_in, addr_in};
        if (w) ld = data_in;
        // byte into the page latch, load window restarts
        if (!w && wp && pw == 0 && wc == 0)
        begin
            pq.push_back({la, ld});
            lq = ld;
            gap = GAP;
        end
        gap = gap > 0 ? gap - 1 : 0;
        // load closes on expiry or a read
        if (pq.size() > 0 && (gap == 0 || r))
        begin
            en = pq.size() > 2 && pq[0] == E0 && pq[1] == E1 && pq[2] == EL;
            dis = pq.size() > 2 && pq[0] == E0 && pq[1] == E1 && pq[2] == EU;
            if (en || dis) pq = pq[3:$];
            if (!lock || en) foreach (pq[i]) mem[pq[i][25:8]] = pq[i][7:0];
            lk_n = (lock || en) && !dis;
            pq.delete();
            wc = WC;
        end
        else if (wc > 0) wc--;
        // protection settles when the period ends
        if (wc == 0) lock = lk_n;
        // toggle bit flips on each new read
        if (r && !rp) tog = !tog;
        rc = r ? rc + 1 : 0;
        // slow array byte, poll byte, or a float that moves every cycle
        q_out <= (r && rc > ACC) ? (wc > 0 ? {~lq[7], tog, lq[5:0]} : mem[{hv_in, addr_in}]) : ~q_out;
        wp = w;
        rp = r;
    end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Testbench of the host controller against the memory model
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import ppea_pkg::*;
;
    logic              clk = 0, rst_b = 0, vld = 0, lst = 0, idr = 0, lk = 0;
    logic [1:0]        opc = 2'h0;
    logic [ADDR_W-1:0] adr = 17'h00000, ab;
    logic [DATA_W-1:0] wd = 8'h00, rdat, dbo, devq, pin, r;
    logic              rdy, rv, rto, bsy, csb, oeb, web, dboe, hv;
    int                mismatches = 0, total_checks = 0;
    // Wire level: the controller when it drives, else the model
    assign pin = dboe ? dbo : devq;
    always #5 clk = ~clk;
    ppea_host #(.WC_CYC(600), .PWR_CYC(20), .GAP_CYC(200)) ppea_host_i (.core_clk_in(clk), .rst_b_in(rst_b),
        .req_valid_in(vld), .req_ready_out(rdy), .req_op_in(opc), .req_addr_in(adr), .req_data_in(wd),
        .req_last_in(lst), .req_id_in(idr), .lock_on_in(lk), .rsp_valid_out(rv), .rsp_data_out(rdat),
        .rsp_timeout_out(rto), .busy_out(bsy), .address_bus_out(ab), .chip_sel_b_out(csb), .out_en_b_out(oeb),
        .wr_strobe_b_out(web), .data_bus_out(dbo), .data_bus_oe_out(dboe), .data_bus_in(pin), .id_area_hv_out(hv));
    ppea_dev_model ppea_dev_model_i (.clk_in(clk), .pwr_ok_in(rst_b), .cs_b_in(csb), .oe_b_in(oeb),
        .we_b_in(web), .hv_in(hv), .addr_in(ab), .data_in(pin), .q_out(devq));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        mismatches += int'(g !== e);
        if (g !== e) $display("ERROR %s expected %h seen %h", nm, e, g);
    endtask
    // One request held until taken, then its answer awaited
    task automatic op(input logic [1:0] o, input logic [16:0] a, input logic [7:0] d, input logic l, i);
        int n;
        n = 0;
        {opc, adr, wd, lst, idr, vld} = {o, a, d, l, i, 1'b1};
        while (rdy !== 1'b1 && n < 9000) @(posedge clk) #1 n++;
        @(posedge clk) #1 vld = 1'b0;
        while (rv !== 1'b1 && n < 9000) @(posedge clk) #1 n++;
        r = rdat;
        // A wait that runs out of its limit counts as a mismatch
        chk("wait limit", 8'h00, {7'h00, n >= 9000});
        chk("timeout", 8'h00, {7'h00, rto});
    endtask
    task automatic rd(input logic [16:0] a, input logic i, input logic [7:0] e);
        op(OP_READ, a, 8'h00, 1'b1, i);
        chk("read data", e, r);
    endtask
    task automatic t_reset;
        @(posedge clk) #1 chk("idle pins", 8'h0E, {4'h0, bsy, web, csb, dboe});
        $display("test reset done");
    endtask
    task automatic t_byte;
        op(OP_WRITE, 17'h00100, 8'h5A, 1'b1, 1'b0);
        rd(17'h00100, 1'b0, 8'h5A);
        op(OP_WRITE, 17'h1FF80, 8'hA5, 1'b1, 1'b1);
        rd(17'h1FF80, 1'b1, 8'hA5);
        rd(17'h1FF80, 1'b0, 8'h00);
        $display("test byte done");
    endtask
    task automatic t_page;
        op(OP_WRITE, 17'h00205, 8'h11, 1'b0, 1'b0);
        op(OP_WRITE, 17'h00201, 8'h22, 1'b0, 1'b0);
        op(OP_WRITE, 17'h00205, 8'h33, 1'b1, 1'b0);
        rd(17'h00205, 1'b0, 8'h33);
        rd(17'h00202, 1'b0, 8'h00);
        for (int k = 0; k < PAGE_BYTES; k++) op(OP_WRITE, 17'h00400 + k[16:0], k[7:0], k == 127, 1'b0);
        rd(17'h00400, 1'b0, 8'h00);
        rd(17'h0047F, 1'b0, 8'h7F);
        $display("test page done");
    endtask
    task automatic t_lock;
        op(OP_WRITE, 17'h00300, 8'h12, 1'b1, 1'b0);
        op(OP_LOCK, 17'h00000, 8'h00, 1'b1, 1'b0);
        op(OP_WRITE, 17'h00300, 8'h1C, 1'b1, 1'b0);
        rd(17'h00300, 1'b0, 8'h12);
        lk = 1'b1;
        op(OP_WRITE, 17'h00300, 8'h2C, 1'b1, 1'b0);
        lk = 1'b0;
        rd(17'h00300, 1'b0, 8'h2C);
        op(OP_UNLOCK, 17'h00000, 8'h00, 1'b1, 1'b0);
        op(OP_WRITE, 17'h00300, 8'h3C, 1'b1, 1'b0);
        rd(17'h00300, 1'b0, 8'h3C);
        rd(17'h00001, 1'b0, 8'h00);
        $display("test lock done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        t_reset;
        t_byte;
        t_page;
        t_lock;
        report_and_stop;
    end
    // Far beyond the expected run of some five thousand cycles
    initial
    begin
        #800000 mismatches++;
        report_and_stop;
    end
endmodule
`default_nettype wire
